// ### fgr_refresh.sv
`timescale 1ns/10ps
`include "fgr_defines.svh"
module fgr_refresh
  import fgr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        ck_link,
  input  wire logic        link_rst_b,
  input  wire logic        cs_n,
  input  wire logic        act_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic        bg0,
  input  wire logic [1:0]  ba,
  input  wire logic [13:0] addr,
  output fgr_mode_t        mode,
  output logic             mode_reserved,
  output fgr_gran_t        cur_gran,
  output logic             refresh_busy,
  output logic             refresh_done,
  output logic             gran_violation,
  output logic [7:0]       refi_div
);
  // ----------------------------------------------------------------
  // link-side command capture
  // ----------------------------------------------------------------
  logic       is_ref, is_mrs;
  logic       ev_reg, ev_next;
  logic [3:0] evd_reg, evd_next;

  always_comb begin
    is_ref   = cmd_hit(cs_n, act_n, ras_n, cas_n, we_n, 1'b1);
    is_mrs   = cmd_hit(cs_n, act_n, ras_n, cas_n, we_n, 1'b0);
    ev_next  = is_ref || (is_mrs && ba == `FGR_MR3_SEL);
    evd_next = {1'b0, 2'h0, bg0};
    if (is_mrs) begin
      evd_next = {1'b1, addr[`FGR_MODE_MSB:`FGR_MODE_LSB]};
    end
    if (!link_rst_b) begin
      ev_next  = 1'b0;
      evd_next = 4'h0;
    end
  end

  always_ff @(posedge ck_link) begin
    ev_reg  <= ev_next;
    evd_reg <= evd_next;
  end

  logic       cmd_p;
  logic [3:0] cmd_d;

  fgr_sync #(.W(4)) u_sync (
    .src_clk   (ck_link),
    .src_rst_b (link_rst_b),
    .src_pulse (ev_reg),
    .src_data  (evd_reg),
    .dst_clk   (mclk),
    .dst_rst_b (rst_b),
    .dst_pulse (cmd_p),
    .dst_data  (cmd_d)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic fgr_gran_t gran_of(fgr_mode_t m, logic b);
    unique case (m)
      FGR_FIX2:  gran_of = FGR_G2;
      FGR_FIX4:  gran_of = FGR_G4;
      FGR_OTF12: gran_of = b ? FGR_G2 : FGR_G1;
      FGR_OTF14: gran_of = b ? FGR_G4 : FGR_G1;
      default:   gran_of = FGR_G1;
    endcase
  endfunction

  function automatic logic [`FGR_CNT_W-1:0] rfc_of(fgr_gran_t g);
    unique case (g)
      FGR_G2:  rfc_of = `FGR_CNT_W'(`FGR_RFC2_CYC);
      FGR_G4:  rfc_of = `FGR_CNT_W'(`FGR_RFC4_CYC);
      default: rfc_of = `FGR_CNT_W'(`FGR_RFC1_CYC);
    endcase
  endfunction

  // shared pin decode; we_n tells a refresh from a mode write
  function automatic logic cmd_hit(logic c, logic a, logic r, logic s, logic w, logic w_want);
    cmd_hit = !c && a && !r && !s && (w == w_want);
  endfunction

  function automatic logic is_rsv(fgr_mode_t m);
    is_rsv = (m == FGR_RSV3) || (m == FGR_RSV4) || (m == FGR_RSV7);
  endfunction

  // refreshes per base interval
  function automatic logic [7:0] rate_of(fgr_gran_t g);
    unique case (g)
      FGR_G2:  rate_of = 8'h02;
      FGR_G4:  rate_of = 8'h04;
      default: rate_of = 8'h01;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // crossed command events
  // ----------------------------------------------------------------
  logic ev_ref, ev_mrs;

  assign ev_ref = cmd_p && !cmd_d[3];
  assign ev_mrs = cmd_p && cmd_d[3];

  // ----------------------------------------------------------------
  // mode register
  // ----------------------------------------------------------------
  fgr_mode_t                mode_reg, mode_next;
  logic                     rsv_reg,  rsv_next;

  always_comb begin
    mode_next = mode_reg;
    if (ev_mrs) begin
      mode_next = fgr_mode_t'(cmd_d[2:0]);
    end
    if (!rst_b) begin
      mode_next = fgr_mode_t'(`FGR_MODE_RST);
    end
    rsv_next = is_rsv(mode_next);
  end

  always_ff @(posedge mclk) begin
    mode_reg <= mode_next;
    rsv_reg  <= rsv_next;
  end

  // ----------------------------------------------------------------
  // refresh timing
  // ----------------------------------------------------------------
  fgr_gran_t                gran_reg, gran_next;
  fgr_state_t               st_reg,   st_next;
  logic [`FGR_CNT_W-1:0]    cnt_reg,  cnt_next;
  logic                     done_reg, done_next;
  logic                     viol_reg, viol_next;
  logic [7:0]               div_reg,  div_next;
  fgr_gran_t                g_new;

  // a refresh inside the cycle time is dropped, only flagged; a mode write there is flagged and still loads mode_reg
  always_comb begin
    gran_next = gran_reg;
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    viol_next = 1'b0;
    g_new     = gran_of(mode_reg, cmd_d[0]);
    unique case (st_reg)
      FGR_IDLE: begin
        if (ev_ref) begin
          gran_next = g_new;
          cnt_next  = rfc_of(g_new);
          st_next   = FGR_BUSY;
        end
      end
      FGR_BUSY: begin
        if (cmd_p) begin
          viol_next = 1'b1;
        end
        if (cnt_reg <= `FGR_CNT_W'(1)) begin
          st_next   = FGR_IDLE;
          done_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - `FGR_CNT_W'(1);
        end
      end
      default: st_next = FGR_IDLE;
    endcase
    if (!rst_b) begin
      gran_next = FGR_G1;
      st_next   = FGR_IDLE;
      cnt_next  = '0;
      done_next = 1'b0;
      viol_next = 1'b0;
    end
    div_next = rate_of(gran_next);
  end

  always_ff @(posedge mclk) begin
    gran_reg <= gran_next;
    st_reg   <= st_next;
    cnt_reg  <= cnt_next;
    done_reg <= done_next;
    viol_reg <= viol_next;
    div_reg  <= div_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign mode           = mode_reg;
  assign mode_reserved  = rsv_reg;
  assign cur_gran       = gran_reg;
  assign refresh_busy   = (st_reg == FGR_BUSY);
  assign refresh_done   = done_reg;
  assign gran_violation = viol_reg;
  // 1, 2 or 4 refreshes per base interval
  assign refi_div       = div_reg;
endmodule

// ### fgr_defines.svh
`ifndef FGR_DEFINES_SVH
`define FGR_DEFINES_SVH

// ----------------------------------------------------------------
// mode register field
// ----------------------------------------------------------------
`define FGR_MR_SEL_W      2
`define FGR_MR3_SEL       2'h3
`define FGR_MODE_MSB      8
`define FGR_MODE_LSB      6
`define FGR_MODE_RST      3'h0
`define FGR_CODE_FIX1     3'h0
`define FGR_CODE_FIX2     3'h1
`define FGR_CODE_FIX4     3'h2
`define FGR_CODE_OTF12    3'h5
`define FGR_CODE_OTF14    3'h6

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FGR_CLK_MHZ       50
`define FGR_REFI_BASE_NS  7800
`define FGR_RFC1_NS       350
`define FGR_RFC2_NS       260
`define FGR_RFC4_NS       160
`define FGR_NS_TO_CYC(ns) (((ns) * `FGR_CLK_MHZ + 999) / 1000)
`define FGR_RFC1_CYC      `FGR_NS_TO_CYC(`FGR_RFC1_NS)
`define FGR_RFC2_CYC      `FGR_NS_TO_CYC(`FGR_RFC2_NS)
`define FGR_RFC4_CYC      `FGR_NS_TO_CYC(`FGR_RFC4_NS)
`define FGR_CNT_W         8

`endif

// ### fgr_pkg.sv
package fgr_pkg;
  typedef enum logic [2:0] {
    FGR_FIX1  = 3'h0,
    FGR_FIX2  = 3'h1,
    FGR_FIX4  = 3'h2,
    FGR_OTF12 = 3'h5,
    FGR_OTF14 = 3'h6,
    FGR_RSV3  = 3'h3,
    FGR_RSV4  = 3'h4,
    FGR_RSV7  = 3'h7
  } fgr_mode_t;

  typedef enum logic [1:0] {
    FGR_G1 = 2'h0,
    FGR_G2 = 2'h1,
    FGR_G4 = 2'h3
  } fgr_gran_t;

  typedef enum logic [1:0] {
    FGR_IDLE = 2'h0,
    FGR_BUSY = 2'h1
  } fgr_state_t;
endpackage

// ### fgr_sync.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// toggle crossing for one-cycle events with a word
// ----------------------------------------------------------------
module fgr_sync #(
  parameter int W = 2
) (
  input  wire logic         src_clk,
  input  wire logic         src_rst_b,
  input  wire logic         src_pulse,
  input  wire logic [W-1:0] src_data,
  input  wire logic         dst_clk,
  input  wire logic         dst_rst_b,
  output logic              dst_pulse,
  output logic [W-1:0]      dst_data
);
  logic         tog_reg,  tog_next;
  logic [W-1:0] word_reg, word_next;
  logic [2:0]   sy_reg,   sy_next;
  logic [W-1:0] out_reg,  out_next;
  logic         pls_reg,  pls_next;

  always_comb begin
    tog_next  = tog_reg ^ src_pulse;
    word_next = src_pulse ? src_data : word_reg;
    if (!src_rst_b) begin
      tog_next  = 1'b0;
      word_next = '0;
    end
  end

  always_ff @(posedge src_clk) begin
    tog_reg  <= tog_next;
    word_reg <= word_next;
  end

  // word is stable for several source cycles before the toggle lands
  always_comb begin
    sy_next  = {sy_reg[1:0], tog_reg};
    pls_next = sy_reg[2] ^ sy_reg[1];
    out_next = (sy_reg[2] ^ sy_reg[1]) ? word_reg : out_reg;
    if (!dst_rst_b) begin
      sy_next  = 3'h0;
      pls_next = 1'b0;
      out_next = '0;
    end
  end

  always_ff @(posedge dst_clk) begin
    sy_reg  <= sy_next;
    pls_reg <= pls_next;
    out_reg <= out_next;
  end

  // pulse and word leave the same flop stage together
  assign dst_pulse = pls_reg;
  assign dst_data  = out_reg;
endmodule

// ### fgr_monitor.sv
`timescale 1ns/10ps
module fgr_monitor
  import fgr_pkg::*;
(
  input logic       mclk,
  input logic       rst_b,
  input fgr_mode_t  mode,
  input logic       mode_reserved,
  input fgr_gran_t  cur_gran,
  input logic       refresh_busy,
  input logic       refresh_done,
  input logic       gran_violation,
  input logic [7:0] refi_div
);
  logic [7:0] len_reg, len_next, exp_len;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // busy length counter
  always_comb begin
    len_next = refresh_busy ? len_reg + 8'h01 : 8'h00;
    exp_len = cur_gran == FGR_G4 ? 8'h08 : cur_gran == FGR_G2 ? 8'h0D : 8'h12;
  end
  always_ff @(posedge mclk) begin
    len_reg <= rst_b ? len_next : 8'h00;
  end
  property p_rsv; mode_reserved == (mode inside {FGR_RSV3, FGR_RSV4, FGR_RSV7}); endproperty
  property p_div; refi_div == (cur_gran == FGR_G4 ? 8'h04 : cur_gran == FGR_G2 ? 8'h02 : 8'h01); endproperty
  property p_len; $fell(refresh_busy) |-> len_reg == exp_len; endproperty
  property p_done; refresh_done |-> $past(refresh_busy) && !refresh_busy; endproperty
  property p_fix;
    $rose(refresh_busy) && !mode[2] |-> cur_gran == (mode == FGR_FIX2 ? FGR_G2 : mode == FGR_FIX4 ? FGR_G4 : FGR_G1);
  endproperty
  property p_otf;
    $rose(refresh_busy) && mode[2] |-> cur_gran == FGR_G1 ||
      cur_gran == (mode == FGR_OTF14 ? FGR_G4 : mode == FGR_OTF12 ? FGR_G2 : FGR_G1);
  endproperty
  property p_rst; $rose(rst_b) |-> mode == FGR_FIX1 && cur_gran == FGR_G1 && !refresh_busy; endproperty
  property p_vio; gran_violation |-> $past(refresh_busy); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
  a_div: assert property (p_div) else $error("rate divider wrong");
  a_len: assert property (p_len) else $error("busy length wrong");
  a_done: assert property (p_done) else $error("done not at busy end");
  a_fix: assert property (p_fix) else $error("fixed granularity wrong");
  a_otf: assert property (p_otf) else $error("otf granularity wrong");
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_vio: assert property (p_vio) else $error("violation while idle");
  c_otf: cover property ($rose(refresh_busy) && cur_gran == FGR_G2 && mode == FGR_OTF12);
  c_rsv: cover property ($rose(refresh_busy) && mode_reserved);
  c_vio: cover property (gran_violation);
  c_g4: cover property ($rose(refresh_busy) && cur_gran == FGR_G4 && mode == FGR_OTF14);
endmodule
bind fgr_refresh fgr_monitor u_fgr_monitor (.mclk, .rst_b, .mode, .mode_reserved, .cur_gran, .refresh_busy,
  .refresh_done, .gran_violation, .refi_div);

// ### fgr_ctrl_model.sv
`timescale 1ns/10ps
module fgr_ctrl_model (
  input  wire logic        ck_link,
  output wire logic        cs_n,
  output wire logic        act_n,
  output wire logic        ras_n,
  output wire logic        cas_n,
  output wire logic        we_n,
  output wire logic        bg0,
  output wire logic [1:0]  ba,
  output wire logic [13:0] addr
);
  logic [21:0] bus_reg = 22'h3FFFFF;
  assign {cs_n, act_n, ras_n, cas_n, we_n, bg0, ba, addr} = bus_reg;
  // one command for one link cycle, then deselect with scrambled lines
  task automatic cmd(input logic w, input logic b, input logic [1:0] a, input logic [13:0] d);
    @(posedge ck_link);
    #1 bus_reg = {4'h4, w, b, a, d};
    @(posedge ck_link);
    #1 bus_reg = {5'h1F, ~bus_reg[16:0]};
  endtask
endmodule

// ### tb_fine_granularity_refresh_mode.sv
`timescale 1ns/10ps
module tb_fine_granularity_refresh_mode
  import fgr_pkg::*;
;
  logic        mclk, rst_b, ck_link, cs_n, act_n, ras_n, cas_n, we_n, bg0;
  logic [1:0]  ba;
  logic [13:0] addr;
  fgr_mode_t   mode;
  fgr_gran_t   cur_gran;
  logic        mode_reserved, refresh_busy, refresh_done, gran_violation;
  logic [7:0]  refi_div;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  fgr_refresh u_fgr_refresh (.mclk, .rst_b, .ck_link, .link_rst_b(rst_b), .cs_n, .act_n, .ras_n, .cas_n,
    .we_n, .bg0, .ba, .addr, .mode, .mode_reserved, .cur_gran, .refresh_busy, .refresh_done,
    .gran_violation, .refi_div);
  fgr_ctrl_model u_fgr_ctrl_model (.ck_link, .cs_n, .act_n, .ras_n, .cas_n, .we_n, .bg0, .ba, .addr);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    ck_link = 1'b0;
    #1.7;
    forever #3 ck_link = ~ck_link;
  end
  task automatic step();
    @(posedge mclk);
    #2;
  endtask
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic [13:0] mk(input int c);
    logic [13:0] a;
    a = 14'($urandom);
    a[8:6] = 3'(c);
    return a;
  endfunction
  // one refresh; dbl sends a second one while busy
  task automatic do_ref(input logic b, input int c, input logic dbl);
    int g, n;
    logic v;
    g = (c == 1 || c == 5 && b) ? 2 : (c == 2 || c == 6 && b) ? 4 : 1;
    v = 1'b0;
    n = 0;
    u_fgr_ctrl_model.cmd(1'b1, b, 2'($urandom), mk(0));
    while (refresh_busy !== 1'b1 && n < 30) begin
      step();
      n++;
    end
    chk(refresh_busy === 1'b1 && cur_gran === fgr_gran_t'(g - 1) && refi_div === 8'(g), "granularity");
    if (dbl)
      fork
        u_fgr_ctrl_model.cmd(1'b1, b, 2'h0, mk(0));
      join_none
    n = 0;
    while (refresh_busy === 1'b1 && n < 40) begin
      step();
      v |= gran_violation;
      n++;
    end
    chk(n == ((g == 4 ? 160 : g == 2 ? 260 : 350) + 19) / 20 && refresh_done === 1'b1, "cycle time");
    chk(v === dbl, "violation flag");
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("CHECK FAILED %0t timeout", $time);
      summarize();
    end
  end
  initial begin
    rst_b = 1'b0;
    void'($urandom(32'h399a));
    repeat (20) @(posedge mclk);
    #1 rst_b = 1'b1;
    step();
    chk(mode === FGR_FIX1 && cur_gran === FGR_G1 && refi_div === 8'h01 && refresh_busy === 1'b0, "reset");
    for (int c = 0; c < 8; c++) begin
      u_fgr_ctrl_model.cmd(1'b0, 1'b0, 2'h3, mk(c));
      repeat (8) step();
      chk(mode === fgr_mode_t'(3'(c)) && mode_reserved === 1'(c == 3 || c == 4 || c == 7), "mode");
      for (int i = 0; i < 5; i++) do_ref(i < 4, c, 1'b0);
    end
    u_fgr_ctrl_model.cmd(1'b0, 1'b0, 2'($urandom_range(2, 0)), mk(5));
    repeat (8) step();
    chk(mode === FGR_RSV7, "other register");
    u_fgr_ctrl_model.cmd(1'b0, 1'b0, 2'h3, mk(0));
    repeat (8) step();
    do_ref(1'b1, 0, 1'b1);
    summarize();
  end
endmodule
